// ---- dv/nv_sram_model.sv ----
// Behavioural nonvolatile SRAM that answers the host controller's pins.
`timescale 1ns/1ps
`default_nettype none
module nv_sram_model #(
	parameter logic [89:0] STORE_SEQ = {6{15'h0000}},
	parameter logic [89:0] RECALL_SEQ = {6{15'h0001}},
	parameter int STORE_NS = 1200,
	parameter int RECALL_NS = 400
)
(
	input wire logic [14:0] addr_in,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic [7:0] d_o,
	input wire logic d_oe,
	input wire logic p_o,
	input wire logic p_oe,
	input wire logic pwr_cycle,
	output logic [7:0] bus,
	output logic pad
);
	logic [7:0] mem [32768];
	logic [7:0] shadow [32768];
	logic [7:0] last = 8'h00;
	logic [89:0] hist = 90'h0;
	logic [14:0] cur = 15'h0000;
	logic busy = 1'b1;
	logic wrote = 1'b0;
	logic drv;
	int cnt = 0;
	task automatic nv_op(input logic st);
		busy = 1'b1;
		if (st)
		begin
			shadow = mem;
			#STORE_NS;
		end
		else
		begin
			foreach (mem[i]) mem[i] = 8'h00;
			mem = shadow;
			#RECALL_NS;
		end
		cnt = 0;
		busy = 1'b0;
	endtask
	// The pad has a pull-up, so it rests high once both sides release it.
	assign pad = !(busy || (p_oe && !p_o));
	assign drv = !busy && !chip_en_n && write_en_n && !out_en_n && !d_oe;
	// A released bus shows the inverse of its last level, so stale data never reads back.
	always_comb bus = d_oe ? d_o : (drv ? mem[addr_in] : ~last);
	always @(bus) if (d_oe || drv) last = bus;
	always @*
		if (!busy && !chip_en_n && !write_en_n)
		begin
			mem[addr_in] = bus;
			wrote = 1'b1;
		end
	initial
	begin
		foreach (shadow[i]) shadow[i] = 8'h00;
		nv_op(1'b0);
	end
	always @(negedge out_en_n or negedge write_en_n) cur = addr_in;
	always @(posedge p_oe) if (!p_o && !busy) nv_op(1'b1);
	// A power cycle stores on the way down, loses the array, and recalls on the way up.
	always @(posedge pwr_cycle)
		if (!busy)
		begin
			nv_op(1'b1);
			foreach (mem[i]) mem[i] = ~mem[i];
			nv_op(1'b0);
		end
	always @(posedge chip_en_n)
		if (!busy)
		begin
			if (wrote)
				cnt = 0;
			else
			begin
				hist = {hist[74:0], cur};
				cnt++;
				if (cnt >= 6 && hist == STORE_SEQ) nv_op(1'b1);
				else if (cnt >= 6 && hist == RECALL_SEQ) nv_op(1'b0);
			end
			wrote = 1'b0;
		end
endmodule
`default_nettype wire

// ---- dv/test_nv_sram_host.sv ----
// Self-checking bench for the nonvolatile SRAM host controller.
`timescale 1ns/1ps
`default_nettype none
module test_nv_sram_host;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	logic hw_store_req = 1'b0;
	logic pwr_cycle = 1'b0;
	nv_ctrl_pkg::cmd_t req_cmd = nv_ctrl_pkg::CMD_READ;
	logic [14:0] req_addr = 15'h0000;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready, rsp_valid, nv_busy, d_oe, chip_en_n, write_en_n, out_en_n, pad, p_o, p_oe;
	logic [7:0] rsp_rdata, d_o, bus;
	logic [7:0] lfsr = 8'h60;
	logic [14:0] addr_in;
	logic [7:0] mem_exp [4];
	logic [7:0] expq [$];
	int error_cnt = 0;
	int n_checks = 0;
	always #20 sys_clk = ~sys_clk;
	nv_sram_host #(.STORE_WAIT(50), .RECALL_WAIT(20)) dut (.sys_clk, .resetn, .req_valid, .req_cmd,
		.req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .hw_store_req, .nv_busy,
		.addr_in, .data_io_i(bus), .data_io_o(d_o), .data_io_oe(d_oe), .chip_en_n, .write_en_n,
		.out_en_n, .hw_store_busy_pad_i(pad), .hw_store_busy_pad_o(p_o), .hw_store_busy_pad_oe(p_oe));
	nv_sram_model mdl (.addr_in, .chip_en_n, .write_en_n, .out_en_n, .d_o, .d_oe, .p_o, .p_oe,
		.bus, .pad, .pwr_cycle);
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic req(input nv_ctrl_pkg::cmd_t c, input logic [14:0] a, input logic [7:0] d);
		int i;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_wdata = d;
		i = 0;
		// Ready is read at the falling edge, where it has settled; the next rising edge takes it.
		while (req_ready !== 1'b1 && i < 3000)
		begin
			@(negedge sys_clk);
			i++;
		end
		if (i >= 3000)
		begin
			error_cnt++;
			final_report();
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		expq.push_back(e);
		req(nv_ctrl_pkg::CMD_READ, a, 8'h00);
	endtask
	// A cleared keep flag writes the inverse, so only a real reload brings the values back.
	task automatic fill(input logic keep);
		for (int i = 0; i < 4; i++)
		begin
			lfsr = lfsr_next(lfsr);
			if (keep) mem_exp[i] = lfsr;
			req(nv_ctrl_pkg::CMD_WRITE, {13'h0040, i[1:0]}, keep ? mem_exp[i] : ~mem_exp[i]);
		end
	endtask
	task automatic check_all();
		for (int i = 0; i < 4; i++)
			rd({13'h0040, i[1:0]}, mem_exp[i]);
	endtask
	task automatic wait_busy();
		for (int i = 0; i < 100 && nv_busy !== 1'b1; i++) @(negedge sys_clk);
		chk({7'h00, nv_busy}, 8'h01);
		if (nv_busy !== 1'b1) final_report();
		repeat (2) @(negedge sys_clk);
		chk({6'h00, req_ready, pad}, 8'h00);
	endtask
	// The answer is looked at mid-cycle, away from the edge that launches it.
	always @(negedge sys_clk)
		if (rsp_valid === 1'b1)
		begin
			if (expq.size() == 0)
				chk(8'h00, 8'h01);
			else
				chk(rsp_rdata, expq.pop_front());
		end
	initial
	begin
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		rd(15'h0107, 8'h00);
		fill(1'b1);
		check_all();
		req(nv_ctrl_pkg::CMD_STORE_SW, 15'h0000, 8'h00);
		wait_busy();
		fill(1'b0);
		repeat (2)
		begin
			req(nv_ctrl_pkg::CMD_RECALL_SW, 15'h0000, 8'h00);
			check_all();
		end
		req(nv_ctrl_pkg::CMD_WRITE, 15'h0001, 8'h5A);
		repeat (5) rd(15'h0001, 8'h5A);
		req(nv_ctrl_pkg::CMD_WRITE, 15'h0105, 8'hA5);
		rd(15'h0001, 8'h5A);
		rd(15'h0105, 8'hA5);
		fill(1'b1);
		hw_store_req = 1'b1;
		wait_busy();
		hw_store_req = 1'b0;
		fill(1'b0);
		req(nv_ctrl_pkg::CMD_RECALL_SW, 15'h0000, 8'h00);
		check_all();
		fill(1'b1);
		repeat (8) @(negedge sys_clk);
		pwr_cycle = 1'b1;
		@(negedge sys_clk);
		pwr_cycle = 1'b0;
		check_all();
		repeat (10) @(negedge sys_clk);
		chk({7'h00, expq.size() == 0}, 8'h01);
		final_report();
	end
endmodule
`default_nettype wire

// ---- hw/nv_ctrl_defines.svh ----
// Widths, depth, timing figures and sequence length for the nonvolatile SRAM host controller.
`ifndef NV_CTRL_DEFINES_SVH
`define NV_CTRL_DEFINES_SVH
`define ADDR_W 15
`define DATA_W 8
`define MEM_DEPTH 32768
`define CLK_NS 40
`define STORE_MAX_NS 10000000
`define RECALL_MAX_NS 20000
`define STORE_CYC (`STORE_MAX_NS / `CLK_NS)
`define RECALL_CYC (`RECALL_MAX_NS / `CLK_NS)
`define STROBE_CYC 2
`define SEQ_LEN 6
`endif

// ---- hw/nv_ctrl_pkg.sv ----
// Types shared by the nonvolatile SRAM host controller.
package nv_ctrl_pkg;
	typedef enum logic [1:0] {
		CMD_READ = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_STORE_SW = 2'h2,
		CMD_RECALL_SW = 2'h3
	} cmd_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STROBE = 6'h04,
		ST_HOLD = 6'h08,
		ST_HWSTORE = 6'h10,
		ST_BUSY = 6'h20
	} state_t;
endpackage

// ---- hw/nv_cycle_timer.sv ----
// Cycle counter that times strobe widths and nonvolatile operation waits.
`timescale 1ns/1ps
`default_nettype none
module nv_cycle_timer
(
	input wire logic sys_clk,
	input wire logic resetn,
	nv_pin_if.timer tp
);
	logic [31:0] count;
	logic running;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			count <= 32'h0;
			running <= 1'b0;
		end
		else if (tp.start)
		begin
			count <= 32'h0;
			running <= 1'b1;
		end
		else if (running && count + 32'h1 >= tp.limit)
			running <= 1'b0;
		else if (running)
			count <= count + 32'h1;
	end

	assign tp.done = running && (count + 32'h1 >= tp.limit);
endmodule
`default_nettype wire

// ---- hw/nv_pin_if.sv ----
// Strobe timing handshake between the controller and its pin cycle timer.
`timescale 1ns/1ps
`default_nettype none
interface nv_pin_if;
	logic start;
	logic [31:0] limit;
	logic done;
	modport ctrl (output start, output limit, input done);
	modport timer (input start, input limit, output done);
endinterface
`default_nettype wire

// ---- hw/nv_sram_host.sv ----
// Host controller that drives a nonvolatile SRAM through its parallel pins.
//
// Overview of operation
// - Host may start STORE by software address sequence or store pad.
// - Host issues sequence accesses back to back with nothing between.
// - Host may start RECALL with its own software address sequence.
// - Chip enable high is standby; write low writes; output enable low reads.
`timescale 1ns/1ps
`default_nettype none
`include "nv_ctrl_defines.svh"
module nv_sram_host #(
	parameter int STORE_WAIT = `STORE_CYC,
	parameter int RECALL_WAIT = `RECALL_CYC,
	parameter logic [`SEQ_LEN*`ADDR_W-1:0] STORE_SEQ = {6{15'h0000}},
	parameter logic [`SEQ_LEN*`ADDR_W-1:0] RECALL_SEQ = {6{15'h0001}}
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire nv_ctrl_pkg::cmd_t req_cmd,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [`DATA_W-1:0] rsp_rdata,
	input wire logic hw_store_req,
	output logic nv_busy,
	output logic [`ADDR_W-1:0] addr_in,
	input wire logic [`DATA_W-1:0] data_io_i,
	output logic [`DATA_W-1:0] data_io_o,
	output logic data_io_oe,
	output logic chip_en_n,
	output logic write_en_n,
	output logic out_en_n,
	input wire logic hw_store_busy_pad_i,
	output logic hw_store_busy_pad_o,
	output logic hw_store_busy_pad_oe
);
	nv_ctrl_pkg::state_t state;
	nv_ctrl_pkg::cmd_t cmd;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] wdata;
	logic [2:0] seq_idx;
	logic is_seq;
	logic is_write;
	logic busy_seen;
	nv_pin_if tp();

	nv_cycle_timer u_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.tp(tp)
	);

	// Picks the address of step idx in a packed sequence list.
	function automatic logic [`ADDR_W-1:0] seq_addr(
		input logic [`SEQ_LEN*`ADDR_W-1:0] list,
		input logic [2:0] idx
	);
		seq_addr = list[idx*`ADDR_W +: `ADDR_W];
	endfunction

	// A pending hardware store wins the idle slot, so ready must not promise it to a request.
	assign req_ready = (state == nv_ctrl_pkg::ST_IDLE) && hw_store_busy_pad_i && !hw_store_req;
	assign nv_busy = (state == nv_ctrl_pkg::ST_BUSY) || (state == nv_ctrl_pkg::ST_HWSTORE);
	assign is_seq = (cmd == nv_ctrl_pkg::CMD_STORE_SW) || (cmd == nv_ctrl_pkg::CMD_RECALL_SW);
	assign is_write = (cmd == nv_ctrl_pkg::CMD_WRITE);

	always_comb
	begin
		tp.start = 1'b0;
		tp.limit = 32'(`STROBE_CYC);
		case (state)
			nv_ctrl_pkg::ST_SETUP: tp.start = 1'b1;
			nv_ctrl_pkg::ST_HOLD:
			begin
				tp.start = is_seq && (seq_idx == 3'(`SEQ_LEN - 1));
				tp.limit = (cmd == nv_ctrl_pkg::CMD_STORE_SW) ? STORE_WAIT : RECALL_WAIT;
			end
			nv_ctrl_pkg::ST_HWSTORE:
			begin
				tp.start = 1'b1;
				tp.limit = STORE_WAIT;
			end
			nv_ctrl_pkg::ST_BUSY:
				tp.limit = (cmd == nv_ctrl_pkg::CMD_RECALL_SW) ? RECALL_WAIT : STORE_WAIT;
			default: tp.limit = 32'(`STROBE_CYC);
		endcase
	end

	// Sequencer of pin cycles; a sequence runs all its reads with no gap for foreign accesses.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			state <= nv_ctrl_pkg::ST_IDLE;
			cmd <= nv_ctrl_pkg::CMD_READ;
			addr <= 15'h0000;
			wdata <= 8'h00;
			seq_idx <= 3'h0;
			busy_seen <= 1'b0;
		end
		else
		begin
			case (state)
				nv_ctrl_pkg::ST_IDLE:
					if (hw_store_req && hw_store_busy_pad_i)
					begin
						// Mark the wait as a store so the busy timeout uses the store limit.
						cmd <= nv_ctrl_pkg::CMD_STORE_SW;
						state <= nv_ctrl_pkg::ST_HWSTORE;
					end
					else if (req_valid && req_ready)
					begin
						cmd <= req_cmd;
						wdata <= req_wdata;
						seq_idx <= 3'h0;
						if (req_cmd == nv_ctrl_pkg::CMD_STORE_SW)
							addr <= seq_addr(STORE_SEQ, 3'h0);
						else if (req_cmd == nv_ctrl_pkg::CMD_RECALL_SW)
							addr <= seq_addr(RECALL_SEQ, 3'h0);
						else
							addr <= req_addr;
						state <= nv_ctrl_pkg::ST_SETUP;
					end
				nv_ctrl_pkg::ST_SETUP: state <= nv_ctrl_pkg::ST_STROBE;
				nv_ctrl_pkg::ST_STROBE:
					if (tp.done)
						state <= nv_ctrl_pkg::ST_HOLD;
				nv_ctrl_pkg::ST_HOLD:
					if (is_seq && seq_idx != 3'(`SEQ_LEN - 1))
					begin
						// Next sequence access follows at once.
						seq_idx <= seq_idx + 3'h1;
						addr <= seq_addr((cmd == nv_ctrl_pkg::CMD_STORE_SW) ? STORE_SEQ : RECALL_SEQ,
							3'(seq_idx + 3'h1));
						state <= nv_ctrl_pkg::ST_SETUP;
					end
					else if (is_seq)
					begin
						busy_seen <= 1'b0;
						state <= nv_ctrl_pkg::ST_BUSY;
					end
					else
						state <= nv_ctrl_pkg::ST_IDLE;
				nv_ctrl_pkg::ST_HWSTORE:
				begin
					busy_seen <= 1'b0;
					state <= nv_ctrl_pkg::ST_BUSY;
				end
				nv_ctrl_pkg::ST_BUSY:
				begin
					// Wait out the operation; the pad going low then high again ends it early.
					if (!hw_store_busy_pad_i)
						busy_seen <= 1'b1;
					if (tp.done || (busy_seen && hw_store_busy_pad_i))
						state <= nv_ctrl_pkg::ST_IDLE;
				end
				default: state <= nv_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// Pin drive from flip-flops so strobes never glitch.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			chip_en_n <= 1'b1;
			write_en_n <= 1'b1;
			out_en_n <= 1'b1;
			data_io_oe <= 1'b0;
			data_io_o <= 8'h00;
			addr_in <= 15'h0000;
			hw_store_busy_pad_o <= 1'b1;
			hw_store_busy_pad_oe <= 1'b0;
		end
		else
		begin
			addr_in <= addr;
			data_io_o <= wdata;
			chip_en_n <= !(state == nv_ctrl_pkg::ST_SETUP || state == nv_ctrl_pkg::ST_STROBE);
			write_en_n <= !(state == nv_ctrl_pkg::ST_STROBE && is_write);
			out_en_n <= !(state == nv_ctrl_pkg::ST_STROBE && !is_write);
			data_io_oe <= is_write && (state == nv_ctrl_pkg::ST_SETUP
				|| state == nv_ctrl_pkg::ST_STROBE || state == nv_ctrl_pkg::ST_HOLD);
			// Pulse the pad low for one cycle to request a store.
			hw_store_busy_pad_o <= 1'b0;
			hw_store_busy_pad_oe <= (state == nv_ctrl_pkg::ST_HWSTORE);
		end
	end

	// Read data is captured at the end of the strobe.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end
		else
		begin
			rsp_valid <= (state == nv_ctrl_pkg::ST_HOLD) && (cmd == nv_ctrl_pkg::CMD_READ);
			if (state == nv_ctrl_pkg::ST_STROBE && tp.done && cmd == nv_ctrl_pkg::CMD_READ)
				rsp_rdata <= data_io_i;
		end
	end

	a_no_access_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		nv_busy |-> ##1 chip_en_n)
		else $error("chip enabled during nonvolatile operation");

	a_write_strobe: assert property (@(posedge sys_clk) disable iff (!resetn)
		!write_en_n |-> !chip_en_n && data_io_oe && out_en_n)
		else $error("write strobe without select or data drive");

	a_read_strobe: assert property (@(posedge sys_clk) disable iff (!resetn)
		!out_en_n |-> !chip_en_n && !data_io_oe && write_en_n)
		else $error("read strobe with bad pin state");

	sequence s_hw_pulse;
		state == nv_ctrl_pkg::ST_HWSTORE ##1 hw_store_busy_pad_oe && !hw_store_busy_pad_o;
	endsequence

	a_hw_store_pad: assert property (@(posedge sys_clk) disable iff (!resetn)
		state == nv_ctrl_pkg::ST_HWSTORE |-> s_hw_pulse)
		else $error("store pad not pulled");

	a_seq_no_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
		state == nv_ctrl_pkg::ST_HOLD && is_seq && seq_idx != 3'(`SEQ_LEN - 1)
		|=> state == nv_ctrl_pkg::ST_SETUP)
		else $error("gap inside initiation sequence");

	a_seq_to_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		state == nv_ctrl_pkg::ST_HOLD && is_seq && seq_idx == 3'(`SEQ_LEN - 1)
		|=> nv_busy && !req_ready)
		else $error("sequence did not wait for operation");

	a_recall_seq_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
		state == nv_ctrl_pkg::ST_SETUP && cmd == nv_ctrl_pkg::CMD_RECALL_SW
		|-> addr == seq_addr(RECALL_SEQ, seq_idx))
		else $error("recall sequence address wrong");

	a_read_resp: assert property (@(posedge sys_clk) disable iff (!resetn)
		state == nv_ctrl_pkg::ST_HOLD && cmd == nv_ctrl_pkg::CMD_READ |=> rsp_valid)
		else $error("read answer missing");
endmodule
`default_nettype wire
